// ==== src/port_pointer_flag_bank.sv ====
// port, scratch index, byte ram index and system flag bank behind a wishbone slave
//
// Notes on behaviour
// - reading the port value returns the present input pin levels.
// - writing the port value drives that byte onto the output latch.
// - a port-to-port copy loads the sampled inputs into the output latch.
// - each input bit readable alone; absent pin positions read as zero.
// - each output latch bit writable alone; absent positions are not kept.
// - smallest variant implements input bits 0 to 4 only.
// - ports A to D each have an input byte and a direction byte.
// - direction bit picks input or output per pin, settable bit by bit.
// - indirect access hits the scratch byte at the current index.
// - post-increment form accesses, then adds one to the index.
// - post-decrement form accesses, then subtracts one from the index.
// - small scratch variant has an eight-bit index with bit aliases.
// - large variant index is ten bits, low byte plus two high bits.
// - byte ram index offers plain, post-increment and post-decrement access.
// - flag 5 serial receive, flag 6 slave bus write, flag 7 timer overflow.
// - without interrupt flags, flag bits 0 to 4 have no hardware source.
// - flags 0-2 external interrupts, 3 any of them, 4 comparator.
// - a flag whose source is unused acts as a plain read-write bit.
// - post-increment happens after the access completes, by exactly one.
// - large scratch holds 1024 bytes, all reached by the ten-bit index.
module port_pointer_flag_bank #(
  parameter logic [7:0] IN_MASK       = 8'hFF,
  parameter logic [7:0] OUT_MASK      = 8'hFF,
  parameter int         SCR_AW        = 10,
  parameter int         RAM_AW        = 8,
  parameter bit         HAS_IRQ_FLAGS = 1'b1
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire port_bank_pkg::wb_req_t   wb_i,
  output port_bank_pkg::wb_rsp_t        wb_o,
  input  wire logic [3:0][7:0]          port_pins_i,
  output logic [3:0][7:0]               port_pins_o,
  output logic [3:0][7:0]               port_oe_n_o,
  input  wire logic [2:0]               ext_irq_i,
  input  wire port_bank_pkg::hw_event_t hw_evt_i
);

  `include "port_bank_regs.svh"

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    return a[8:2] == off[8:2];
  endfunction : hit

  function automatic logic [7:0] set_bit(input logic [7:0] v,
                                         input logic [2:0] n,
                                         input logic       b);
    logic [7:0] r;
    r    = v;
    r[n] = b;
    return r;
  endfunction : set_bit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0][7:0]           pin_meta_r;
  logic [3:0][7:0]           pin_sync_r;
  logic [3:0][7:0]           in_val;
  logic [2:0]                irq_meta_r;
  logic [2:0]                irq_sync_r;
  logic [2:0]                irq_prev_r;
  logic [2:0]                irq_rise;
  logic                      req;
  logic                      fetch;
  logic                      commit;
  logic                      wr;
  logic                      alias_wr;
  logic [8:0]                adr;
  logic [7:0]                wdat;
  logic [2:0]                tgt;
  logic [2:0]                bitn;
  logic                      ack_r;
  logic [7:0]                rdat_r;
  logic [7:0]                rd_mux;
  logic [7:0]                latch_r;
  logic [7:0]                dir_r [`NUM_PORTS];
  logic [7:0]                flags_r;
  logic [7:0]                flags_nxt;
  logic [7:0]                src_en_r;
  logic [7:0]                hw_raw;
  logic [7:0]                hw_set;
  logic                      scr_hit;
  logic                      scr_ld_lo;
  logic                      scr_ld_hi;
  logic [7:0]                scr_ld_dat;
  port_bank_pkg::step_mode_t scr_mode;
  logic [7:0]                scr_rdat;
  logic [SCR_AW-1:0]         scr_idx;
  logic [7:0]                scr_lo;
  logic [7:0]                scr_hi;
  logic                      ram_hit;
  logic                      ram_ld;
  port_bank_pkg::step_mode_t ram_mode;
  logic [7:0]                ram_rdat;
  logic [RAM_AW-1:0]         ram_idx;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pins are asynchronous; only the second stage is looked at
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= port_pins_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_meta_r <= 3'h7;
      irq_sync_r <= 3'h7;
      irq_prev_r <= 3'h7; // all high: a pin held high through reset gives no false edge
    end else begin
      irq_meta_r <= ext_irq_i;
      irq_sync_r <= irq_meta_r;
      irq_prev_r <= irq_sync_r;
    end
  end

  assign irq_rise = irq_sync_r & ~irq_prev_r;

  // ----------------------------------------------------------------
  // per-port pin view
  // ----------------------------------------------------------------
  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    // absent input positions of the main port read as zero
    assign in_val[p] = pin_sync_r[p] & ((p == `PORT_B) ? IN_MASK : 8'hFF);
    assign port_pins_o[p] = (p == `PORT_B) ? latch_r : 8'h00;
    assign port_oe_n_o[p] = ~dir_r[p];
  end

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  // request cycle latches read data, ack cycle commits all side effects,
  // so a post-step never happens before the master has the old byte
  assign req      = wb_i.cyc & wb_i.stb;
  assign fetch    = req & ~ack_r;
  assign commit   = req & ack_r;
  assign wr       = commit & wb_i.we & wb_i.sel[0];
  assign adr      = wb_i.adr;
  assign wdat     = wb_i.dat[7:0];
  assign tgt      = adr[7:5];
  assign bitn     = adr[4:2];
  assign alias_wr = wr & adr[8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= fetch;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= `RST_BYTE;
    end else if (fetch) begin
      rdat_r <= rd_mux;
    end
  end

  assign wb_o = '{ack: ack_r, dat: {24'h000000, rdat_r}};

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (adr[8]) begin
      case (tgt)
        `TGT_IN:   rd_mux = {7'h00, in_val[`PORT_B][bitn]};
        `TGT_OUT:  rd_mux = 8'h00;
        `TGT_SCR:  rd_mux = {7'h00, scr_lo[bitn]};
        `TGT_FLAG: rd_mux = {7'h00, flags_r[bitn]};
        default:   rd_mux = {7'h00, dir_r[2'(tgt - `TGT_DIR_A)][bitn]};
      endcase
    end else begin
      case ({adr[8:2], 2'b00})
        `OFF_IN_VAL:  rd_mux = in_val[`PORT_B];
        `OFF_IN_A:    rd_mux = in_val[0];
        `OFF_IN_A + 9'h004: rd_mux = in_val[1];
        `OFF_IN_A + 9'h008: rd_mux = in_val[2];
        `OFF_IN_A + 9'h00C: rd_mux = in_val[3];
        `OFF_DIR_A:   rd_mux = dir_r[0];
        `OFF_DIR_A + 9'h004: rd_mux = dir_r[1];
        `OFF_DIR_A + 9'h008: rd_mux = dir_r[2];
        `OFF_DIR_A + 9'h00C: rd_mux = dir_r[3];
        `OFF_SCR_LO:  rd_mux = scr_lo;
        `OFF_SCR_HI:  rd_mux = scr_hi;
        `OFF_SCR_DAT: rd_mux = scr_rdat;
        `OFF_SCR_INC: rd_mux = scr_rdat;
        `OFF_SCR_DEC: rd_mux = scr_rdat;
        `OFF_RAM_IDX: rd_mux = ram_idx[7:0];
        `OFF_RAM_DAT: rd_mux = ram_rdat;
        `OFF_RAM_INC: rd_mux = ram_rdat;
        `OFF_RAM_DEC: rd_mux = ram_rdat;
        `OFF_FLAGS:   rd_mux = flags_r;
        `OFF_SRC_EN:  rd_mux = src_en_r;
        default:      rd_mux = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output latch
  // ----------------------------------------------------------------
  // bits with no output pin behind them are never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_r <= `RST_BYTE;
    end else if (wr && (hit(adr, `OFF_IN_VAL) || hit(adr, `OFF_OUT_LATCH))) begin
      latch_r <= wdat & OUT_MASK;
    end else if (wr && hit(adr, `OFF_PORT_COPY)) begin
      latch_r <= in_val[`PORT_B] & OUT_MASK;
    end else if (alias_wr && tgt == `TGT_OUT) begin
      latch_r <= set_bit(latch_r, bitn, wdat[0]) & OUT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------
  // a set bit makes the pin an output
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (rst_i) begin
        dir_r[p] <= `RST_BYTE;
      end else if (wr && hit(adr, `OFF_DIR_A + 9'(4 * p))) begin
        dir_r[p] <= wdat;
      end else if (alias_wr && tgt == 3'(p + 2)) begin
        dir_r[p] <= set_bit(dir_r[p], bitn, wdat[0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // scratch memory and its index
  // ----------------------------------------------------------------
  assign scr_hit = hit(adr, `OFF_SCR_DAT) | hit(adr, `OFF_SCR_INC) |
                   hit(adr, `OFF_SCR_DEC);
  assign scr_lo  = scr_idx[7:0];
  assign scr_hi  = 8'(scr_idx >> 8);

  always_comb begin
    if (hit(adr, `OFF_SCR_INC)) begin
      scr_mode = port_bank_pkg::ACC_INC;
    end else if (hit(adr, `OFF_SCR_DEC)) begin
      scr_mode = port_bank_pkg::ACC_DEC;
    end else begin
      scr_mode = port_bank_pkg::ACC_PLAIN;
    end
  end

  // bit alias rewrites the low byte with one bit replaced
  assign scr_ld_lo  = (wr & ~adr[8] & hit(adr, `OFF_SCR_LO)) |
                      (alias_wr & (tgt == `TGT_SCR));
  assign scr_ld_hi  = wr & ~adr[8] & hit(adr, `OFF_SCR_HI);
  assign scr_ld_dat = adr[8] ? set_bit(scr_lo, bitn, wdat[0]) : wdat;

  indexed_ram #(
    .AW(SCR_AW)
  ) u_scratch (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_lo_i (scr_ld_lo),
    .load_hi_i (scr_ld_hi),
    .load_dat_i(scr_ld_dat),
    .commit_i  (commit & ~adr[8] & scr_hit),
    .we_i      (wb_i.we & wb_i.sel[0]),
    .mode_i    (scr_mode),
    .wdat_i    (wdat),
    .rdat_o    (scr_rdat),
    .index_o   (scr_idx)
  );

  // ----------------------------------------------------------------
  // byte ram and its index
  // ----------------------------------------------------------------
  assign ram_hit = hit(adr, `OFF_RAM_DAT) | hit(adr, `OFF_RAM_INC) |
                   hit(adr, `OFF_RAM_DEC);
  assign ram_ld  = wr & ~adr[8] & hit(adr, `OFF_RAM_IDX);

  always_comb begin
    if (hit(adr, `OFF_RAM_INC)) begin
      ram_mode = port_bank_pkg::ACC_INC;
    end else if (hit(adr, `OFF_RAM_DEC)) begin
      ram_mode = port_bank_pkg::ACC_DEC;
    end else begin
      ram_mode = port_bank_pkg::ACC_PLAIN;
    end
  end

  indexed_ram #(
    .AW(RAM_AW)
  ) u_byte_ram (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_lo_i (ram_ld),
    .load_hi_i (1'b0),
    .load_dat_i(wdat),
    .commit_i  (commit & ~adr[8] & ram_hit),
    .we_i      (wb_i.we & wb_i.sel[0]),
    .mode_i    (ram_mode),
    .wdat_i    (wdat),
    .rdat_o    (ram_rdat),
    .index_o   (ram_idx)
  );

  // ----------------------------------------------------------------
  // system flags
  // ----------------------------------------------------------------
  // without the interrupt option bits 0..4 only ever change by software
  assign hw_raw[2:0] = HAS_IRQ_FLAGS ? irq_rise : 3'h0;
  assign hw_raw[3]   = HAS_IRQ_FLAGS & (|irq_rise);
  assign hw_raw[4]   = HAS_IRQ_FLAGS & hw_evt_i.cmp_change;
  assign hw_raw[5]   = hw_evt_i.rx_done;
  assign hw_raw[6]   = hw_evt_i.slave_write_event;
  assign hw_raw[7]   = hw_evt_i.timer_ovf;

  // a disabled source leaves the bit as a plain user bit
  assign hw_set = hw_raw & src_en_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_en_r <= `RST_SRC_EN;
    end else if (wr && ~adr[8] && hit(adr, `OFF_SRC_EN)) begin
      src_en_r <= wdat;
    end
  end

  // set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    flags_nxt = flags_r;
    if (wr && ~adr[8] && hit(adr, `OFF_FLAGS)) begin
      flags_nxt = wdat;
    end else if (alias_wr && tgt == `TGT_FLAG) begin
      flags_nxt = set_bit(flags_r, bitn, wdat[0]);
    end
    flags_nxt = flags_nxt | hw_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= `RST_BYTE;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule : port_pointer_flag_bank

// ==== src/port_bank_regs.svh ====
// register offsets, alias targets and reset values of the port, pointer and flag bank
`ifndef PORT_BANK_REGS_SVH
`define PORT_BANK_REGS_SVH

// ----------------------------------------------------------------
// byte offsets of the word registers
// ----------------------------------------------------------------
`define OFF_IN_VAL     9'h000
`define OFF_OUT_LATCH  9'h004
`define OFF_PORT_COPY  9'h008
`define OFF_DIR_A      9'h010
`define OFF_IN_A       9'h020
`define OFF_SCR_LO     9'h030
`define OFF_SCR_HI     9'h034
`define OFF_SCR_DAT    9'h038
`define OFF_SCR_INC    9'h03C
`define OFF_SCR_DEC    9'h040
`define OFF_RAM_IDX    9'h044
`define OFF_RAM_DAT    9'h048
`define OFF_RAM_INC    9'h04C
`define OFF_RAM_DEC    9'h050
`define OFF_FLAGS      9'h054
`define OFF_SRC_EN     9'h058

// ----------------------------------------------------------------
// single-bit alias window: adr[8]=1, target adr[7:5], bit adr[4:2]
// ----------------------------------------------------------------
`define TGT_IN         3'h0
`define TGT_OUT        3'h1
`define TGT_DIR_A      3'h2
`define TGT_SCR        3'h6
`define TGT_FLAG       3'h7

// ----------------------------------------------------------------
// reset values and fixed positions
// ----------------------------------------------------------------
`define RST_BYTE       8'h00
`define RST_SRC_EN     8'hFF
`define PORT_B         1
`define NUM_PORTS      4

`endif

// ==== src/port_bank_pkg.sv ====
// types shared by the port, pointer and flag bank
package port_bank_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [8:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic cmp_change;
    logic rx_done;
    logic slave_write_event;
    logic timer_ovf;
  } hw_event_t;

  typedef enum logic [1:0] {
    ACC_PLAIN,
    ACC_INC,
    ACC_DEC
  } step_mode_t;

endpackage : port_bank_pkg

// ==== src/indexed_ram.sv ====
// byte memory reached through an index register with post-increment and post-decrement
module indexed_ram #(
  parameter int AW = 10
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      load_lo_i,
  input  wire logic                      load_hi_i,
  input  wire logic [7:0]                load_dat_i,
  input  wire logic                      commit_i,
  input  wire logic                      we_i,
  input  wire port_bank_pkg::step_mode_t mode_i,
  input  wire logic [7:0]                wdat_i,
  output logic [7:0]                     rdat_o,
  output logic [AW-1:0]                  index_o
);

  logic [7:0]    mem [2**AW];
  logic [AW-1:0] index_r;
  logic [AW-1:0] index_nxt;
  logic [AW-1:0] lo_mask;

  assign lo_mask = AW'(8'hFF);
  assign rdat_o  = mem[index_r];
  assign index_o = index_r;

  // ----------------------------------------------------------------
  // index update
  // ----------------------------------------------------------------
  // the high byte only keeps the bits above bit 7 that exist; the rest fall away
  always_comb begin
    index_nxt = index_r;
    if (load_lo_i) begin
      index_nxt = (index_r & ~lo_mask) | AW'(load_dat_i);
    end else if (load_hi_i) begin
      index_nxt = (index_r & lo_mask) | (AW'(load_dat_i) << 8);
    end else if (commit_i && mode_i == port_bank_pkg::ACC_INC) begin
      index_nxt = index_r + AW'(1);
    end else if (commit_i && mode_i == port_bank_pkg::ACC_DEC) begin
      index_nxt = index_r - AW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_r <= '0;
    end else begin
      index_r <= index_nxt;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // write lands at the old index; the step is applied at the same edge
  always_ff @(posedge clk_i) begin
    if (commit_i && we_i) begin
      mem[index_r] <= wdat_i;
    end
  end

endmodule : indexed_ram

// ==== testbench/port_bank_checker_assertions.sv ====
// concurrent checks on the ports of the port, pointer and flag bank
`include "port_bank_regs.svh"
module port_bank_checker (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire port_bank_pkg::wb_req_t   wb_i,
  input  wire port_bank_pkg::wb_rsp_t   wb_o,
  input  wire logic [3:0][7:0]          port_pins_i,
  input  wire logic [3:0][7:0]          port_pins_o,
  input  wire logic [3:0][7:0]          port_oe_n_o,
  input  wire logic [2:0]               ext_irq_i,
  input  wire port_bank_pkg::hw_event_t hw_evt_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic req_w;
  logic wr_w;
  assign req_w = wb_i.cyc && wb_i.stb;
  assign wr_w  = req_w && wb_o.ack && wb_i.we;

  property p_ack_latency;
    req_w && !wb_o.ack |=> wb_o.ack;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("ack late");
  property p_ack_pulse;
    wb_o.ack |=> !wb_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_o.ack |-> $past(req_w);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_upper;
    wb_o.ack |-> wb_o.dat[31:8] == 24'h000000;
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
  property p_latch_write;
    wr_w && wb_i.sel[0] && wb_i.adr == `OFF_IN_VAL |=> port_pins_o[1] == $past(wb_i.dat[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not written");
  property p_dir_write;
    wr_w && wb_i.sel[0] && wb_i.adr == `OFF_DIR_A |=> port_oe_n_o[0] == ~$past(wb_i.dat[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not written");
  property p_latch_hold;
    !wr_w |=> $stable(port_pins_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved alone");
  property p_dir_hold;
    !wr_w |=> $stable(port_oe_n_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved alone");
  property p_wo_read;
    req_w && !wb_o.ack && !wb_i.we && wb_i.adr == `OFF_OUT_LATCH |=> wb_o.dat[7:0] == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("latch readable");

  c_write: cover property (wr_w);
  c_inc_read: cover property (wb_o.ack && !wb_i.we && wb_i.adr == `OFF_SCR_INC);
  c_flags: cover property (wb_o.ack && wb_i.adr == `OFF_FLAGS);
endmodule : port_bank_checker

bind port_pointer_flag_bank port_bank_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .port_pins_i(port_pins_i),
  .port_pins_o(port_pins_o), .port_oe_n_o(port_oe_n_o), .ext_irq_i(ext_irq_i),
  .hw_evt_i(hw_evt_i)
);

// ==== testbench/ext_port_model.sv ====
// circuitry outside the port pins
module ext_port_model (
  input  wire logic [3:0][7:0] pins_o_i,
  input  wire logic [3:0][7:0] oe_n_i,
  input  wire logic [3:0][7:0] drive_i,
  output logic      [3:0][7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // the device wins where it drives, so a wrong direction bit shows as a wrong level
  assign level_o = (pins_o_i & ~oe_n_i) | (drive_i & oe_n_i);
endmodule : ext_port_model

// ==== testbench/test_port_pointer_flag_bank.sv ====
// self-checking bench of the port, pointer and flag bank
`include "port_bank_regs.svh"
module test_port_pointer_flag_bank;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       we;
    logic [8:0] adr;
    logic [7:0] val;
  } row_t;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  logic                     clk_i = 1'b0;
  logic                     rst_i = 1'b1;
  port_bank_pkg::wb_req_t   req   = '0;
  port_bank_pkg::wb_rsp_t   rsp;
  port_bank_pkg::hw_event_t evt   = '0;
  logic [2:0]               irq   = 3'h0;
  logic [3:0][7:0]          drv   = '0;
  logic [3:0][7:0]          pins_in;
  logic [3:0][7:0]          pins_out;
  logic [3:0][7:0]          oe_n;
  logic [7:0]               rd;
  int                       n_errors = 0;
  int                       samples_checked = 0;
  row_t                     rows [42] = '{
    '{W, 9'h010, 8'h5A}, '{R, 9'h010, 8'h5A}, '{W, 9'h140, 8'h01}, '{R, 9'h010, 8'h5B},
    '{W, 9'h014, 8'hFF}, '{W, 9'h004, 8'h3C}, '{R, 9'h004, 8'h00}, '{W, 9'h120, 8'h01},
    '{W, 9'h030, 8'h10}, '{W, 9'h03C, 8'hAA}, '{W, 9'h03C, 8'hBB}, '{R, 9'h030, 8'h12},
    '{W, 9'h030, 8'h10}, '{R, 9'h03C, 8'hAA}, '{R, 9'h040, 8'hBB}, '{R, 9'h030, 8'h10},
    '{W, 9'h034, 8'hFF}, '{R, 9'h034, 8'h03}, '{W, 9'h030, 8'hFF}, '{W, 9'h03C, 8'h05},
    '{R, 9'h034, 8'h00}, '{W, 9'h038, 8'h66}, '{R, 9'h040, 8'h66}, '{R, 9'h034, 8'h03},
    '{R, 9'h038, 8'h05}, '{W, 9'h030, 8'h00}, '{W, 9'h1DC, 8'h01}, '{R, 9'h030, 8'h80},
    '{W, 9'h044, 8'h05}, '{W, 9'h04C, 8'h11}, '{W, 9'h04C, 8'h22}, '{R, 9'h044, 8'h07},
    '{W, 9'h044, 8'h06}, '{R, 9'h050, 8'h22}, '{R, 9'h044, 8'h05}, '{R, 9'h048, 8'h11},
    '{W, 9'h00C, 8'h77}, '{R, 9'h00C, 8'h00}, '{W, 9'h054, 8'h0F}, '{R, 9'h054, 8'h0F},
    '{W, 9'h1EC, 8'h00}, '{R, 9'h054, 8'h07}};

  always #10 clk_i = ~clk_i;

  ext_port_model ext (.pins_o_i(pins_out), .oe_n_i(oe_n), .drive_i(drv), .level_o(pins_in));

  port_pointer_flag_bank DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp), .port_pins_i(pins_in),
    .port_pins_o(pins_out), .port_oe_n_o(oe_n), .ext_irq_i(irq), .hw_evt_i(evt)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic wb_xfer(input logic we, input logic [8:0] adr, input logic [7:0] wd,
                         output logic [7:0] rdat);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h0, wd}};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rdat = rsp.dat[7:0];
    req <= '0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("oe_n at reset", 32'hFFFFFFFF, oe_n);
    check("pins_o at reset", 32'h0, pins_out);
    foreach (rows[i]) begin
      wb_xfer(rows[i].we, rows[i].adr, rows[i].val, rd);
      if (!rows[i].we) check("row read", {24'h0, rows[i].val}, {24'h0, rd});
    end
    // ---------------------------------------------------------------
    // port pins
    // ---------------------------------------------------------------
    check("latch after alias", 32'h3D, {24'h0, pins_out[1]});
    wb_xfer(W, `OFF_IN_VAL, 8'hC0, rd);
    check("latch", 32'hC0, {24'h0, pins_out[1]});
    wb_xfer(W, `OFF_DIR_A + 9'h004, 8'h00, rd);
    drv[1] <= 8'hA5;
    drv[0] <= 8'h3C;
    // two sync flops plus margin
    repeat (4) @(posedge clk_i);
    wb_xfer(R, `OFF_IN_VAL, 8'h00, rd);
    check("input value", 32'hA5, {24'h0, rd});
    wb_xfer(R, `OFF_IN_A, 8'h00, rd);
    check("port a level", 32'h24, {24'h0, rd});
    wb_xfer(R, 9'h100, 8'h00, rd);
    check("input bit 0", 32'h1, {24'h0, rd});
    wb_xfer(R, 9'h104, 8'h00, rd);
    check("input bit 1", 32'h0, {24'h0, rd});
    wb_xfer(W, `OFF_PORT_COPY, 8'h00, rd);
    check("copied latch", 32'hA5, {24'h0, pins_out[1]});
    // ---------------------------------------------------------------
    // flags
    // ---------------------------------------------------------------
    wb_xfer(W, `OFF_FLAGS, 8'h00, rd);
    evt <= '1;
    irq <= 3'h7;
    @(posedge clk_i);
    evt <= '0;
    repeat (5) @(posedge clk_i);
    wb_xfer(R, `OFF_FLAGS, 8'h00, rd);
    check("flags set", 32'hFF, {24'h0, rd});
    wb_xfer(R, `OFF_FLAGS, 8'h00, rd);
    check("flags kept", 32'hFF, {24'h0, rd});
    wb_xfer(W, `OFF_FLAGS, 8'h00, rd);
    wb_xfer(W, `OFF_SRC_EN, 8'h00, rd);
    evt <= '1;
    @(posedge clk_i);
    evt <= '0;
    wb_xfer(R, `OFF_FLAGS, 8'h00, rd);
    check("flags unused source", 32'h00, {24'h0, rd});
    // ---------------------------------------------------------------
    // second reset in mid-run
    // ---------------------------------------------------------------
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("oe_n after reset", 32'hFFFFFFFF, oe_n);
    check("pins_o after reset", 32'h0, pins_out);
    wb_xfer(R, `OFF_SCR_LO, 8'h00, rd);
    check("index after reset", 32'h0, {24'h0, rd});
    wb_xfer(R, `OFF_SRC_EN, 8'h00, rd);
    check("source enable", 32'hFF, {24'h0, rd});
    wb_xfer(R, `OFF_FLAGS, 8'h00, rd);
    check("flags after reset", 32'h00, {24'h0, rd});
    // event lands at the very edge that commits the software clear
    fork
      wb_xfer(W, `OFF_FLAGS, 8'h00, rd);
      begin
        @(posedge clk_i);
        evt <= '{timer_ovf: 1'b1, default: 1'b0};
        @(posedge clk_i);
        evt <= '0;
      end
    join
    wb_xfer(R, `OFF_FLAGS, 8'h00, rd);
    check("set beats clear", 32'h80, {24'h0, rd});
    finish_test();
  end
endmodule : test_port_pointer_flag_bank
